// ==== core/tws_eeprom.sv ====
// two-wire serial eeprom slave: framing, addressing, page writes, reads
`timescale 1ns/1ps
`default_nettype none
module tws_eeprom
   import tws_pkg::*;
#(
   parameter bit LARGE_ARRAY = 1'b1,
   parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic chip_select_addr_bit2,
   input wire logic chip_select_addr_bit1,
   input wire logic chip_select_addr_bit0,
   input wire logic wp,
   output logic standby
);
   localparam logic [ARR_AW-1:0] AMASK = LARGE_ARRAY ? MASK_LARGE
                                                     : MASK_SMALL;
   localparam logic [PROG_CW-1:0] PROG_LAST =
      PROG_CW'(PROG_CYCLES - 1);

   // pin synchronisers: stage one feeds stage two only
   logic [5:0] pin_s1_r, pin_s2_r;
   logic scl_d_r, sda_d_r;
   logic scl_s, sda_s, wp_s;
   logic [2:0] cs_s;
   assign scl_s = pin_s2_r[0];
   assign sda_s = pin_s2_r[1];
   assign wp_s = pin_s2_r[2];
   assign cs_s = pin_s2_r[5:3];

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pin_s1_r <= 6'h03;
         pin_s2_r <= 6'h03;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         pin_s1_r <= {chip_select_addr_bit2, chip_select_addr_bit1,
                      chip_select_addr_bit0, wp, sda_in, scl_in};
         pin_s2_r <= pin_s1_r;
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   // edge and framing events on the synchronised pins
   logic scl_rise, scl_fall, start_det, stop_det;
   assign scl_rise = scl_s & ~scl_d_r;
   assign scl_fall = ~scl_s & scl_d_r;
   assign start_det = scl_s & scl_d_r & ~sda_s & sda_d_r;
   assign stop_det = scl_s & scl_d_r & sda_s & ~sda_d_r;

   // protocol state
   tws_state_t state_r, state_nxt;
   tws_kind_t kind_r, kind_nxt;
   logic [3:0] bitcnt_r, bitcnt_nxt;
   logic [7:0] shreg_r, shreg_nxt;
   logic [7:0] addr_hi_r, addr_hi_nxt;
   logic [ARR_AW-1:0] addr_cnt_r, addr_cnt_nxt;
   logic rw_r, rw_nxt;
   logic sda_oe_r, sda_oe_nxt;
   logic host_ack_r, host_ack_nxt;
   logic wr_pend_r, wr_pend_nxt;
   logic [PAGE_BYTES-1:0] mask_r, mask_nxt;
   logic [PROG_CW-1:0] prog_cnt_r, prog_cnt_nxt;
   logic [PAGE_AW:0] cidx_r, cidx_nxt;
   logic standby_r;

   // memory ports
   logic lat_we;
   logic [PAGE_AW-1:0] lat_waddr;
   logic [7:0] lat_rdata, arr_rdata;
   logic arr_we;
   logic [ARR_AW-1:0] arr_waddr;
   logic [PAGE_AW-1:0] commit_idx;

   logic dev_match, byte_done, data_take, load_tx;
   assign dev_match = (shreg_r[7:4] == FAMILY_CODE)
                    && (shreg_r[3:1] == cs_s);
   assign byte_done = (state_r == ST_RX) && scl_fall
                    && (bitcnt_r == BITS_PER_WORD);
   assign data_take = byte_done && (kind_r == K_DATA);
   assign commit_idx = PAGE_AW'(cidx_r - 7'h01);

   // page latch: bytes wait here until the stop starts programming
   tws_ram #(.AW(PAGE_AW), .DW(8)) u_latch (
      .mclk(mclk),
      .we(lat_we),
      .waddr(lat_waddr),
      .wdata(shreg_r),
      .raddr(cidx_r[PAGE_AW-1:0]),
      .rdata_r(lat_rdata)
   );

   // array: read side always follows the address counter
   tws_ram #(.AW(ARR_AW), .DW(8)) u_array (
      .mclk(mclk),
      .we(arr_we),
      .waddr(arr_waddr),
      .wdata(lat_rdata),
      .raddr(addr_cnt_r & AMASK),
      .rdata_r(arr_rdata)
   );

   // latch write of a received data byte unless protected
   always_comb begin
      lat_we = data_take && !wp_s;
      lat_waddr = addr_cnt_r[PAGE_AW-1:0];
   end

   // commit: latch read index leads array write by one cycle
   always_comb begin
      arr_we = (state_r == ST_PROG) && (cidx_r != 7'h00)
             && (cidx_r <= 7'h40) && mask_r[commit_idx];
      arr_waddr = {addr_cnt_r[ARR_AW-1:PAGE_AW], commit_idx};
   end

   // next state of the protocol engine
   always_comb begin
      state_nxt = state_r;
      kind_nxt = kind_r;
      bitcnt_nxt = bitcnt_r;
      shreg_nxt = shreg_r;
      addr_hi_nxt = addr_hi_r;
      addr_cnt_nxt = addr_cnt_r;
      rw_nxt = rw_r;
      sda_oe_nxt = sda_oe_r;
      host_ack_nxt = host_ack_r;
      wr_pend_nxt = wr_pend_r;
      mask_nxt = mask_r;
      prog_cnt_nxt = prog_cnt_r;
      cidx_nxt = cidx_r;
      load_tx = 1'b0;
      if (state_r == ST_PROG) begin
         // bus is deaf while programming; polling gets no ack
         sda_oe_nxt = 1'b0;
         if (cidx_r <= 7'h40) begin
            cidx_nxt = cidx_r + 7'h01;
         end
         prog_cnt_nxt = prog_cnt_r + PROG_CW'(1);
         if (prog_cnt_r == PROG_LAST) begin
            state_nxt = ST_IDLE;
            wr_pend_nxt = 1'b0;
            mask_nxt = '0;
         end
      end else if (start_det) begin
         state_nxt = ST_RX;
         kind_nxt = K_DEV;
         bitcnt_nxt = 4'h0;
         sda_oe_nxt = 1'b0;
      end else if (stop_det) begin
         sda_oe_nxt = 1'b0;
         if (wr_pend_r) begin
            state_nxt = ST_PROG;
            prog_cnt_nxt = '0;
            cidx_nxt = '0;
         end else begin
            state_nxt = ST_IDLE;
         end
      end else begin
         case (state_r)
            ST_RX: begin
               if (scl_rise) begin
                  shreg_nxt = {shreg_r[6:0], sda_s};
                  bitcnt_nxt = bitcnt_r + 4'h1;
               end else if (byte_done) begin
                  state_nxt = ST_ACK;
                  sda_oe_nxt = 1'b1;
                  case (kind_r)
                     K_DEV: begin
                        rw_nxt = shreg_r[0];
                        if (!dev_match) begin
                           state_nxt = ST_IDLE;
                           sda_oe_nxt = 1'b0;
                        end
                     end
                     K_AHI: addr_hi_nxt = shreg_r;
                     K_ALO: begin
                        // new word address starts a fresh page image
                        addr_cnt_nxt = {addr_hi_r[6:0], shreg_r}
                                     & AMASK;
                        mask_nxt = '0;
                        wr_pend_nxt = 1'b0;
                     end
                     default: begin
                        if (!wp_s) begin
                           mask_nxt[addr_cnt_r[PAGE_AW-1:0]] = 1'b1;
                           wr_pend_nxt = 1'b1;
                        end
                        addr_cnt_nxt[PAGE_AW-1:0] =
                           addr_cnt_r[PAGE_AW-1:0] + 6'h01;
                     end
                  endcase
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  sda_oe_nxt = 1'b0;
                  bitcnt_nxt = 4'h0;
                  if (kind_r == K_DEV && rw_r) begin
                     load_tx = 1'b1;
                  end else begin
                     state_nxt = ST_RX;
                     case (kind_r)
                        K_DEV: kind_nxt = K_AHI;
                        K_AHI: kind_nxt = K_ALO;
                        default: kind_nxt = K_DATA;
                     endcase
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (bitcnt_r == TX_LAST_BIT) begin
                     state_nxt = ST_HACK;
                     sda_oe_nxt = 1'b0; // release for host ack
                  end else begin
                     shreg_nxt = {shreg_r[6:0], 1'b0};
                     sda_oe_nxt = ~shreg_r[6];
                     bitcnt_nxt = bitcnt_r + 4'h1;
                  end
               end
            end
            ST_HACK: begin
               if (scl_rise) begin
                  host_ack_nxt = ~sda_s;
               end else if (scl_fall) begin
                  if (host_ack_r) begin
                     load_tx = 1'b1;
                  end else begin
                     state_nxt = ST_IDLE; // nack, await stop
                  end
               end
            end
            ST_IDLE: begin
               sda_oe_nxt = 1'b0;
            end
            default: begin
               state_nxt = ST_IDLE;
               sda_oe_nxt = 1'b0;
            end
         endcase
         // first data bit goes out on the same falling edge
         if (load_tx) begin
            state_nxt = ST_TX;
            shreg_nxt = arr_rdata;
            sda_oe_nxt = ~arr_rdata[7];
            bitcnt_nxt = 4'h0;
            addr_cnt_nxt = (addr_cnt_r + 15'h0001) & AMASK;
         end
      end
   end

   // registers of the protocol engine
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_r <= ST_IDLE;
         kind_r <= K_DEV;
         bitcnt_r <= 4'h0;
         shreg_r <= 8'h00;
         addr_hi_r <= 8'h00;
         addr_cnt_r <= 15'h0000;
         rw_r <= 1'b0;
         sda_oe_r <= 1'b0;
         host_ack_r <= 1'b0;
         wr_pend_r <= 1'b0;
         mask_r <= '0;
         prog_cnt_r <= '0;
         cidx_r <= '0;
         standby_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         kind_r <= kind_nxt;
         bitcnt_r <= bitcnt_nxt;
         shreg_r <= shreg_nxt;
         addr_hi_r <= addr_hi_nxt;
         addr_cnt_r <= addr_cnt_nxt;
         rw_r <= rw_nxt;
         sda_oe_r <= sda_oe_nxt;
         host_ack_r <= host_ack_nxt;
         wr_pend_r <= wr_pend_nxt;
         mask_r <= mask_nxt;
         prog_cnt_r <= prog_cnt_nxt;
         cidx_r <= cidx_nxt;
         standby_r <= (state_nxt == ST_IDLE);
      end
   end

   // open drain: the pin is only ever pulled low
   logic sda_out_r;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sda_out_r <= 1'b0;
      end else begin
         sda_out_r <= 1'b0;
      end
   end
   assign sda_out = sda_out_r;
   assign sda_oe = sda_oe_r;
   assign standby = standby_r;

   // checks on the engine
   sequence s_dev_done;
      byte_done && (kind_r == K_DEV);
   endsequence

   sequence s_prog_entry;
      stop_det && wr_pend_r && (state_r != ST_PROG);
   endsequence

   a_ack_on_match: assert property (@(posedge mclk) disable iff (!resetn)
      s_dev_done ##0 dev_match |=> sda_oe_r && state_r == ST_ACK)
      else $error("matched address not acknowledged");

   a_nomatch_idle: assert property (@(posedge mclk) disable iff (!resetn)
      s_dev_done ##0 !dev_match |=> !sda_oe_r && state_r == ST_IDLE)
      else $error("mismatched address answered");

   a_prog_silent: assert property (@(posedge mclk) disable iff (!resetn)
      state_r == ST_PROG ##1 state_r == ST_PROG |-> !sda_oe_r)
      else $error("bus driven during programming");

   a_wp_blocks: assert property (@(posedge mclk) disable iff (!resetn)
      $rose(wr_pend_r) |-> $past(!wp_s) && $past(data_take))
      else $error("write accepted while protected");

   a_start_any: assert property (@(posedge mclk) disable iff (!resetn)
      start_det && state_r != ST_PROG
      |=> state_r == ST_RX && kind_r == K_DEV && bitcnt_r == 4'h0)
      else $error("start not honoured");

   a_stop_prog: assert property (@(posedge mclk) disable iff (!resetn)
      s_prog_entry |=> state_r == ST_PROG && prog_cnt_r == '0)
      else $error("stop after write did not program");

   a_page_wrap: assert property (@(posedge mclk) disable iff (!resetn)
      data_take |=> addr_cnt_r[14:6] == $past(addr_cnt_r[14:6])
         && addr_cnt_r[5:0] == $past(addr_cnt_r[5:0]) + 6'h01)
      else $error("write address left its page");

   a_prog_time: assert property (@(posedge mclk) disable iff (!resetn)
      $fell(state_r == ST_PROG) |-> $past(prog_cnt_r) == PROG_LAST)
      else $error("programming time wrong");

   a_hack_release: assert property (@(posedge mclk) disable iff (!resetn)
      $rose(state_r == ST_HACK) |-> !sda_oe_r [*2])
      else $error("data held during host acknowledge");
endmodule : tws_eeprom
`default_nettype wire

// ==== core/tws_pkg.sv ====
// constants and types for the two-wire serial eeprom slave
// Summary of operation
// - smaller array: 256 pages of 64 bytes, 14-bit word address
// - larger array: 512 pages of 64 bytes, 15-bit word address
// - data changes only while clock low; changes while high are framing
// - data falling while clock high is a start, seen in any state except programming
// - data rising while clock high is a stop; after reads, standby
// - every word is eight bits; device pulls data low on ninth clock
// - standby at power-up and after stop plus finished internal work
// - device address follows each start; upper nibble must match family code
// - next three bits compare with chip-select pins; floating pins read low (no pull-down here; the pins are used as driven)
// - last device address bit: high reads, low writes
// - match gives acknowledge; mismatch gives none and returns to standby
// - write-protect high inhibits all array writes
// - byte write: address, word address, data, then stop starts programming
// - during programming all bus inputs ignored, no acknowledge
// - page write takes up to 64 bytes before the stop
// - write address increments only low six bits, wrapping in page
// - acknowledge polling: address acknowledged only after programming ends
// - address counter holds last address plus one; reads wrap array end
// - current-address read sends byte at counter; host nacks then stops
// - random read: dummy write of word address, repeated start, read
// - sequential read continues while host acknowledges, wrapping at end
// - programming time from stop to finish at most 5 ms
package tws_pkg;
   localparam int CLK_MHZ = 250;
   localparam int PROG_TIME_US = 5000;
   // longest time: rounds down, here exact
   localparam int PROG_CYCLES_DEF = PROG_TIME_US * CLK_MHZ;
   localparam int PROG_CW = 21;
   localparam int ARR_AW = 15;
   localparam int PAGE_AW = 6;
   localparam int PAGE_BYTES = 64;
   localparam logic [ARR_AW-1:0] MASK_SMALL = 15'h3FFF;
   localparam logic [ARR_AW-1:0] MASK_LARGE = 15'h7FFF;
   localparam logic [3:0] FAMILY_CODE = 4'hA;
   localparam logic [3:0] BITS_PER_WORD = 4'h8;
   localparam logic [3:0] TX_LAST_BIT = 4'h7;
   typedef enum logic [1:0] {K_DEV, K_AHI, K_ALO, K_DATA} tws_kind_t;
   typedef enum logic [2:0] {
      ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_HACK, ST_PROG
   } tws_state_t;
endpackage : tws_pkg

// ==== core/tws_ram.sv ====
// simple dual-port byte memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module tws_ram #(
   parameter int AW = 6,
   parameter int DW = 8
) (
   input wire logic mclk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata_r
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // no reset: contents survive as long as power does
   always_ff @(posedge mclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata_r <= mem[raddr];
   end
endmodule : tws_ram
`default_nettype wire

// ==== test/tws_eeprom_test.sv ====
// self-checking bench for the two-wire eeprom slave
`timescale 1ns/1ps
`default_nettype none
module tws_eeprom_test;
   import tws_pkg::*;
   localparam int PROG = 200;
   localparam int LIMIT = 40000;
   localparam logic [2:0] CS = 3'h5;
   logic mclk, resetn, wp, sda_out, sda_oe, standby, scl, sda_rel;
   logic [2:0] cs;
   wire logic sda;
   int miscompares, n_checks, cycles;
   // pull-up: low only while some party pulls it
   assign sda = ~((sda_oe & ~sda_out) | ~sda_rel);
   tws_host host (.mclk(mclk), .sda(sda), .scl(scl), .sda_rel(sda_rel));
   // short programming time keeps the run brief
   tws_eeprom #(.LARGE_ARRAY(1'b1), .PROG_CYCLES(PROG)) DUT (
      .mclk(mclk), .resetn(resetn), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe),
      .chip_select_addr_bit2(cs[2]), .chip_select_addr_bit1(cs[1]),
      .chip_select_addr_bit0(cs[0]), .wp(wp), .standby(standby));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   task automatic final_report();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report
   // a hang counts as a mismatch
   always @(posedge mclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         final_report();
      end
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk8
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask : chk1
   function automatic logic [7:0] dev(input logic [3:0] fam,
         input logic [2:0] c, input logic rw);
      return {fam, c, rw};
   endfunction : dev
   task automatic put(input logic [7:0] b, input logic exp_ack);
      logic a;
      host.send_byte(b, a);
      chk1(a, exp_ack);
   endtask : put
   task automatic set_addr(input logic [15:0] a);
      host.start();
      put(dev(FAMILY_CODE, CS, 1'b0), 1'b0);
      put(a[15:8], 1'b0);
      put(a[7:0], 1'b0);
   endtask : set_addr
   task automatic wr(input logic [15:0] a, input logic [7:0] d[$]);
      set_addr(a);
      foreach (d[i]) put(d[i], 1'b0);
      host.stop();
   endtask : wr
   // bounded wait for the self-timed cycle to end
   task automatic wait_prog();
      int n;
      n = 0;
      while (standby !== 1'b1 && n < PROG + 60) begin
         @(negedge mclk);
         n++;
      end
      chk1(standby, 1'b1);
   endtask : wait_prog
   task automatic rd(input logic [15:0] a, input logic [7:0] exp[$]);
      logic [7:0] d;
      set_addr(a);
      host.start();
      put(dev(FAMILY_CODE, CS, 1'b1), 1'b0);
      foreach (exp[i]) begin
         host.recv_byte(i == exp.size() - 1, d);
         chk8(d, exp[i]);
      end
      host.stop();
      chk1(standby, 1'b1);
   endtask : rd
   task automatic t_address();
      for (int k = 0; k < 8; k++) begin
         if (k[2:0] == CS) continue;
         host.start();
         put(dev(FAMILY_CODE, k[2:0], 1'b0), 1'b1);
         host.stop();
      end
      host.start();
      put(dev(4'hB, CS, 1'b0), 1'b1);
      host.stop();
      chk1(standby, 1'b1);
   endtask : t_address
   task automatic t_byte_write();
      wr(16'h8123, '{8'h5A});
      chk1(standby, 1'b0);
      host.start();
      put(dev(FAMILY_CODE, CS, 1'b0), 1'b1);
      host.stop();
      wait_prog();
      host.start();
      put(dev(FAMILY_CODE, CS, 1'b0), 1'b0);
      host.stop();
      rd(16'h0123, '{8'h5A});
   endtask : t_byte_write
   task automatic t_page();
      logic [7:0] d;
      wr(16'h017E, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55});
      wait_prog();
      rd(16'h0140, '{8'h33, 8'h44, 8'h55});
      rd(16'h017E, '{8'h11});
      host.start();
      put(dev(FAMILY_CODE, CS, 1'b1), 1'b0);
      host.recv_byte(1'b1, d);
      chk8(d, 8'h22);
      host.stop();
   endtask : t_page
   // protected writes are acked but neither stored nor programmed
   task automatic t_protect();
      @(negedge mclk) wp = 1'b1;
      host.wt(4);
      wr(16'h0123, '{8'hC3});
      chk1(standby, 1'b1);
      wp = 1'b0;
      host.wt(4);
      rd(16'h0123, '{8'h5A});
   endtask : t_protect
   task automatic t_wrap();
      wr(16'h7FFF, '{8'h77});
      wait_prog();
      wr(16'h0000, '{8'h88});
      wait_prog();
      rd(16'h7FFF, '{8'h77, 8'h88});
   endtask : t_wrap
   initial begin
      miscompares = 0;
      n_checks = 0;
      cycles = 0;
      resetn = 1'b0;
      wp = 1'b0;
      cs = CS;
      repeat (10) @(negedge mclk);
      resetn = 1'b1;
      host.wt(4);
      chk1(standby, 1'b1);
      chk1(sda_oe, 1'b0);
      host.recover();
      host.stop();
      t_address();
      t_byte_write();
      t_page();
      t_protect();
      t_wrap();
      final_report();
   end
endmodule : tws_eeprom_test
`default_nettype wire

// ==== test/tws_host.sv ====
// two-wire bus host model: drives the bus clock and open-drain data
`timescale 1ns/1ps
`default_nettype none
module tws_host (
   input wire logic mclk,
   input wire logic sda,
   output logic scl,
   output logic sda_rel
);
   // idle bus: clock high, data released
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end
   // waits whole system clocks, moving only on the falling edge
   task automatic wt(input int n);
      repeat (n) @(negedge mclk);
   endtask : wt
   // data moves two clocks after clock fall, never while clock high
   task automatic low_phase(input logic b);
      scl = 1'b0;
      wt(2);
      sda_rel = b;
      wt(8);
   endtask : low_phase
   // one bit slot of 80 ns, sampled mid-high
   task automatic clk_bit(input logic b, output logic s);
      low_phase(b);
      scl = 1'b1;
      wt(5);
      s = sda;
      wt(5);
   endtask : clk_bit
   task automatic start();
      low_phase(1'b1);
      scl = 1'b1;
      wt(10);
      sda_rel = 1'b0;
      wt(10);
   endtask : start
   task automatic stop();
      low_phase(1'b0);
      scl = 1'b1;
      wt(10);
      sda_rel = 1'b1;
      wt(10);
   endtask : stop
   // clocks until data reads high, then a start
   task automatic recover();
      logic s;
      for (int i = 0; i < 9; i++) begin
         clk_bit(1'b1, s);
         if (s === 1'b1) break;
      end
      start();
   endtask : recover
   // msb first; ack is the level seen on the ninth slot
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
      clk_bit(1'b1, ack);
   endtask : send_byte
   task automatic recv_byte(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
      // ack level stays until clock falls; releasing now would be a stop
      clk_bit(nack, s);
   endtask : recv_byte
endmodule : tws_host
`default_nettype wire
